// file: hdl/atcu_params.svh
// Register map, field positions, reset values and timing counts of the asynchronous timer
`ifndef ATCU_PARAMS_SVH
`define ATCU_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ATCU_OFF_COUNT    8'h00
`define ATCU_OFF_COMPARE  8'h04
`define ATCU_OFF_CONTROL  8'h08
`define ATCU_OFF_STATUS   8'h0C
`define ATCU_OFF_FLAGS    8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define ATCU_ST_ASYNC_BIT 3
`define ATCU_FL_MATCH_BIT 0
`define ATCU_XF_CTL       0
`define ATCU_XF_CMP       1
`define ATCU_XF_CNT       2

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define ATCU_RST_BYTE     8'h00
`define ATCU_IRQ_SYNC_CYC 3
`define ATCU_PRE_W        10
`define ATCU_RESP_OKAY    2'h0
`define ATCU_RESP_SLVERR  2'h2

`endif

// file: hdl/atcu_pkg.sv
// Types and helper functions of the asynchronous timer
package atcu_pkg;

  // ****************************************************************
  // Control register layout
  // ****************************************************************
  typedef struct packed {
    logic [1:0] spare_hi;
    logic [1:0] out_mode;
    logic       spare_lo;
    logic [2:0] clock_prescale_select;
  } atcu_ctl_t;

  typedef enum logic [1:0] {
    ATCU_OUT_OFF,
    ATCU_OUT_TOGGLE,
    ATCU_OUT_CLEAR,
    ATCU_OUT_SET
  } atcu_out_mode_t;

  // Status register layout
  typedef struct packed {
    logic [3:0] spare;
    logic       async_clock_select;
    logic       count_update_busy;
    logic       compare_update_busy;
    logic       control_update_busy;
  } atcu_status_t;

  // Prescaler divide taps: a tick when the low log2(N) bits are all ones
  function automatic logic atcu_div_hit(input logic [2:0] sel, input logic [9:0] cnt);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      3'h0: hit = 1'b0;
      3'h1: hit = 1'b1;
      3'h2: hit = &cnt[2:0];
      3'h3: hit = &cnt[4:0];
      3'h4: hit = &cnt[5:0];
      3'h5: hit = &cnt[6:0];
      3'h6: hit = &cnt[7:0];
      3'h7: hit = &cnt[9:0];
    endcase
    return hit;
  endfunction

  // Word address match, low two bits ignored
  function automatic logic atcu_sel(input logic [7:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

endpackage

// file: hdl/atcu_sync.sv
// Two-stage synchroniser whose stages advance on an enable
`timescale 1ns/1ps
module atcu_sync
  import atcu_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // Stage advance and data
  input  wire logic         adv,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  generate
    if (W < 1) begin : g_chk
      $error("atcu_sync: W must be at least 1");
    end
  endgenerate

  // First stage is read by the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else if (ce && adv) begin
      stage1_r <= d;
      stage2_r <= stage1_r;
    end
  end

  assign q = stage2_r;

endmodule

// file: hdl/atcu_prescale.sv
// Prescaler that turns the timer source clock into the selected timer tick
`timescale 1ns/1ps
`include "atcu_params.svh"
module atcu_prescale
  import atcu_pkg::*;
#(
  parameter int PRE_W = `ATCU_PRE_W
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Source clock enable and selection
  input  wire logic       src_en,
  input  wire logic [2:0] clock_prescale_select,
  // Selected tick
  output logic            tick
);

  logic [PRE_W-1:0] pre_cnt_r;
  logic [PRE_W-1:0] pre_cnt_nxt;
  logic             hit;

  generate
    if (PRE_W < 10) begin : g_chk
      $error("atcu_prescale: PRE_W must reach the divide-by-1024 tap");
    end
  endgenerate

  assign pre_cnt_nxt = pre_cnt_r + {{(PRE_W-1){1'b0}}, 1'b1};
  // R1 - divider tap choice
  assign hit         = atcu_div_hit(clock_prescale_select, pre_cnt_r[9:0]);
  assign tick        = src_en & hit;

  // Free-running so that a change of selection needs no restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= '0;
    end else if (ce && src_en) begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

endmodule

// file: hdl/atcu_timer.sv
// Top of the 8-bit timer with asynchronous clocking and register update handshake
// Summary of operation
// R1 - Select field picks stop, direct, or divided
// R2 - Counter register readable and writable by software
// R3 - Counter write blocks match on next tick
// R4 - Compare register continuously compared with counter
// R5 - Async select bit chooses I/O or crystal
// R6 - Software rewrites registers after clock switch
// R7 - Counter write sets busy until loaded
// R8 - Compare write sets busy until loaded
// R9 - Control write sets busy until loaded
// R10 - Software never writes while busy is set
// R11 - Counter reads live; compare and control read temporaries
// R12 - Writes land after two crystal edges
// R13 - Each register owns its temporary register
// R14 - Compare disabled while counter/compare transfer pending
// R15 - Software waits one crystal cycle before sleep
// R16 - Crystal runs except power-down and standby
// R17 - Wake-up starts on next timer tick
// R18 - Counter read register follows crystal edges
// R19 - Async flag sync: three cycles plus tick
// R20 - Compare pin changes on timer clock
// R21 - Software follows safe clock switching order
// R22 - Software writes, waits busy, then reads counter
// R23 - Match flag set; cleared by ack or one
// R24 - Transfers synchronised both ways by two flops
`timescale 1ns/1ps
`include "atcu_params.svh"
module atcu_timer
  import atcu_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int PRE_W = `ATCU_PRE_W
) (
  // Clock, reset and clock enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Crystal oscillator pin, power state and interrupt acknowledge
  input  wire logic        crystal_osc_in,
  input  wire logic        sleep_active,
  input  wire logic        deep_sleep,
  input  wire logic        irq_ack,
  // Timer outputs
  output logic             compare_output_pin,
  output logic             compare_match_flag,
  output logic             wake_req,
  output logic             osc_enable
);

  generate
    if (CNT_W != 8) begin : g_chk
      $error("atcu_timer: register map serves an 8-bit counter only");
    end
  endgenerate

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic             awready_r;
  logic             wready_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             arready_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;
  logic             aw_got_r;
  logic             w_got_r;
  logic [7:0]       aw_addr_r;
  logic [7:0]       w_byte_r;
  logic             w_lane0_r;
  logic             aw_hs;
  logic             w_hs;
  logic             ar_hs;
  logic             commit;
  logic             aw_got_nxt;
  logic             w_got_nxt;
  logic             bvalid_nxt;
  logic             rvalid_nxt;
  logic             wr_en;
  logic             wr_cnt;
  logic             wr_cmp;
  logic             wr_ctl;
  logic             wr_st;
  logic             wr_fl;
  logic             wr_hit;
  logic             rd_hit;
  logic [7:0]       rd_byte;

  assign aw_hs      = awvalid & awready_r;
  assign w_hs       = wvalid & wready_r;
  assign ar_hs      = arvalid & arready_r;
  assign commit     = aw_got_r & w_got_r & ~bvalid_r;
  assign aw_got_nxt = (aw_got_r | aw_hs) & ~commit;
  assign w_got_nxt  = (w_got_r | w_hs) & ~commit;
  assign bvalid_nxt = commit | (bvalid_r & ~bready);
  assign rvalid_nxt = ar_hs | (rvalid_r & ~rready);

  // Data sit in byte lane 0; other lanes are ignored
  assign wr_en  = commit & w_lane0_r;
  assign wr_cnt = wr_en & atcu_sel(aw_addr_r, `ATCU_OFF_COUNT);
  assign wr_cmp = wr_en & atcu_sel(aw_addr_r, `ATCU_OFF_COMPARE);
  assign wr_ctl = wr_en & atcu_sel(aw_addr_r, `ATCU_OFF_CONTROL);
  assign wr_st  = wr_en & atcu_sel(aw_addr_r, `ATCU_OFF_STATUS);
  assign wr_fl  = wr_en & atcu_sel(aw_addr_r, `ATCU_OFF_FLAGS);
  assign wr_hit = atcu_sel(aw_addr_r, `ATCU_OFF_COUNT) | atcu_sel(aw_addr_r, `ATCU_OFF_COMPARE)
                | atcu_sel(aw_addr_r, `ATCU_OFF_CONTROL) | atcu_sel(aw_addr_r, `ATCU_OFF_STATUS)
                | atcu_sel(aw_addr_r, `ATCU_OFF_FLAGS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `ATCU_RESP_OKAY;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= `ATCU_RST_BYTE;
      w_byte_r  <= `ATCU_RST_BYTE;
      w_lane0_r <= 1'b0;
    end else if (ce) begin
      awready_r <= ~aw_got_nxt & ~bvalid_nxt;
      wready_r  <= ~w_got_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      if (aw_hs) begin
        aw_addr_r <= awaddr;
      end
      if (w_hs) begin
        w_byte_r  <= wdata[7:0];
        w_lane0_r <= wstrb[0];
      end
      if (commit) begin
        bresp_r <= wr_hit ? `ATCU_RESP_OKAY : `ATCU_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `ATCU_RESP_OKAY;
    end else if (ce) begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= {24'h00_0000, rd_byte};
        rresp_r <= rd_hit ? `ATCU_RESP_OKAY : `ATCU_RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Source clock and tick
  // ****************************************************************
  logic             osc_prev_r;
  logic             osc_rise;
  logic             async_sel_r;
  logic             src_en;
  logic             tick;
  atcu_ctl_t        ctl_r;

  // Pin is taken as synchronous; one flop suffices for the edge
  assign osc_rise = crystal_osc_in & ~osc_prev_r;
  // R5 - source clock choice
  assign src_en   = async_sel_r ? osc_rise : 1'b1;

  atcu_prescale #(
    .PRE_W (PRE_W)
  ) u_prescale (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .ce                    (ce),
    .src_en                (src_en),
    .clock_prescale_select (ctl_r.clock_prescale_select),
    .tick                  (tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev_r  <= 1'b0;
      async_sel_r <= 1'b0;
    end else if (ce) begin
      osc_prev_r <= crystal_osc_in;
      // R5 - async select write
      if (wr_st) begin
        async_sel_r <= w_byte_r[`ATCU_ST_ASYNC_BIT];
      end
    end
  end

  // ****************************************************************
  // Temporary registers and update handshake
  // ****************************************************************
  logic [7:0]       tmp_cnt_r;
  logic [7:0]       tmp_cmp_r;
  logic [7:0]       tmp_ctl_r;
  logic [2:0]       wr_vec;
  logic [2:0]       req_tgl_r;
  logic [2:0]       req_osc;
  logic [2:0]       ack_tgl_r;
  logic [2:0]       ack_back;
  logic [2:0]       xfer_load;
  logic [2:0]       busy;

  assign wr_vec    = {wr_cnt, wr_cmp, wr_ctl};
  // R12 - load once request crossed two crystal edges
  assign xfer_load = req_osc ^ ack_tgl_r;
  // R7 - busy from write until load acknowledged
  // R8 - same handshake on the compare slot
  // R9 - same handshake on the control slot
  assign busy      = req_tgl_r ^ ack_back;

  // R24 - request crossing on crystal edges
  atcu_sync #(
    .W (3)
  ) u_req_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .adv     (osc_rise),
    .d       (req_tgl_r),
    .q       (req_osc)
  );

  // R24 - acknowledge back to the bus clock
  atcu_sync #(
    .W (3)
  ) u_ack_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .adv     (1'b1),
    .d       (ack_tgl_r),
    .q       (ack_back)
  );

  // R13 - one temporary and one toggle per register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmp_cnt_r <= `ATCU_RST_BYTE;
      tmp_cmp_r <= `ATCU_RST_BYTE;
      tmp_ctl_r <= `ATCU_RST_BYTE;
      req_tgl_r <= 3'h0;
      ack_tgl_r <= 3'h0;
    end else if (ce) begin
      if (wr_cnt) begin
        tmp_cnt_r <= w_byte_r;
      end
      if (wr_cmp) begin
        tmp_cmp_r <= w_byte_r;
      end
      if (wr_ctl) begin
        tmp_ctl_r <= w_byte_r;
      end
      if (async_sel_r) begin
        req_tgl_r <= req_tgl_r ^ wr_vec;
      end
      ack_tgl_r <= req_osc;
    end
  end

  // ****************************************************************
  // Counter, compare and control
  // ****************************************************************
  logic [7:0]       cnt_r;
  logic [7:0]       cmp_r;
  logic [7:0]       cnt_rd_r;
  logic             ld_cnt;
  logic             ld_cmp;
  logic             ld_ctl;
  logic [7:0]       cnt_src;
  logic [7:0]       cmp_src;
  logic [7:0]       ctl_src;
  logic [7:0]       cnt_inc;

  assign ld_cnt  = async_sel_r ? xfer_load[`ATCU_XF_CNT] : wr_cnt;
  assign ld_cmp  = async_sel_r ? xfer_load[`ATCU_XF_CMP] : wr_cmp;
  assign ld_ctl  = async_sel_r ? xfer_load[`ATCU_XF_CTL] : wr_ctl;
  assign cnt_src = async_sel_r ? tmp_cnt_r : w_byte_r;
  assign cmp_src = async_sel_r ? tmp_cmp_r : w_byte_r;
  assign ctl_src = async_sel_r ? tmp_ctl_r : w_byte_r;
  assign cnt_inc = cnt_r + 8'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= `ATCU_RST_BYTE;
      cmp_r    <= `ATCU_RST_BYTE;
      ctl_r    <= atcu_ctl_t'(`ATCU_RST_BYTE);
      cnt_rd_r <= `ATCU_RST_BYTE;
    end else if (ce) begin
      // R2 - software load beats counting
      if (ld_cnt) begin
        cnt_r <= cnt_src;
      end else if (tick) begin
        cnt_r <= cnt_inc;
      end
      if (ld_cmp) begin
        cmp_r <= cmp_src;
      end
      if (ld_ctl) begin
        ctl_r <= atcu_ctl_t'(ctl_src);
      end
      // R18 - read copy follows crystal edges
      if (!async_sel_r || osc_rise) begin
        cnt_rd_r <= cnt_r;
      end
    end
  end

  // ****************************************************************
  // Compare match, flag and output pin
  // ****************************************************************
  logic             block_r;
  logic             cmp_hold;
  logic             match_evt;
  logic [`ATCU_IRQ_SYNC_CYC-1:0] flag_pipe_r;
  logic             flag_set;
  logic             flag_r;
  logic             flag_clr;
  logic             pin_r;
  atcu_out_mode_t   out_mode;

  // R14 - compare off during counter or compare transfer
  assign cmp_hold  = async_sel_r & (busy[`ATCU_XF_CNT] | busy[`ATCU_XF_CMP]);
  // R4 - equality checked on each tick
  assign match_evt = tick & (cnt_r == cmp_r) & ~block_r & ~cmp_hold;
  // R19 - async flag delayed three bus cycles after tick
  assign flag_set  = async_sel_r ? flag_pipe_r[`ATCU_IRQ_SYNC_CYC-1] : match_evt;
  assign flag_clr  = irq_ack | (wr_fl & w_byte_r[`ATCU_FL_MATCH_BIT]);
  assign out_mode  = atcu_out_mode_t'(ctl_r.out_mode);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_r     <= 1'b0;
      flag_pipe_r <= '0;
      flag_r      <= 1'b0;
      pin_r       <= 1'b0;
    end else if (ce) begin
      // R3 - counter load blocks the match on the following tick
      if (ld_cnt) begin
        block_r <= 1'b1;
      end else if (tick) begin
        block_r <= 1'b0;
      end
      flag_pipe_r <= async_sel_r ? {flag_pipe_r[`ATCU_IRQ_SYNC_CYC-2:0], match_evt} : '0;
      // R23 - set wins over clear
      if (flag_set) begin
        flag_r <= 1'b1;
      end else if (flag_clr) begin
        flag_r <= 1'b0;
      end
      // R20 - pin acts on the raw timer event
      if (match_evt) begin
        unique case (out_mode)
          ATCU_OUT_OFF:    pin_r <= pin_r;
          ATCU_OUT_TOGGLE: pin_r <= ~pin_r;
          ATCU_OUT_CLEAR:  pin_r <= 1'b0;
          ATCU_OUT_SET:    pin_r <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // Sleep and wake-up
  // ****************************************************************
  logic             wake_pend_r;
  logic             wake_r;
  logic             osc_en_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_pend_r <= 1'b0;
      wake_r      <= 1'b0;
      osc_en_r    <= 1'b0;
    end else if (ce) begin
      // R17 - wake request waits for next tick
      if (!sleep_active) begin
        wake_pend_r <= 1'b0;
        wake_r      <= 1'b0;
      end else begin
        if (flag_set) begin
          wake_pend_r <= 1'b1;
        end
        if (wake_pend_r && tick) begin
          wake_r <= 1'b1;
        end
      end
      // R16 - crystal kept alive while async select is set, outside deep sleep
      osc_en_r <= async_sel_r & ~deep_sleep;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  atcu_status_t     st;

  assign st.spare               = 4'h0;
  assign st.async_clock_select  = async_sel_r;
  assign st.count_update_busy   = busy[`ATCU_XF_CNT];
  assign st.compare_update_busy = busy[`ATCU_XF_CMP];
  assign st.control_update_busy = busy[`ATCU_XF_CTL];

  // R11 - live count, temporaries for compare and control
  assign rd_byte = atcu_sel(araddr, `ATCU_OFF_COUNT)   ? cnt_rd_r :
                   atcu_sel(araddr, `ATCU_OFF_COMPARE) ? tmp_cmp_r :
                   atcu_sel(araddr, `ATCU_OFF_CONTROL) ? tmp_ctl_r :
                   atcu_sel(araddr, `ATCU_OFF_STATUS)  ? st :
                   atcu_sel(araddr, `ATCU_OFF_FLAGS)   ? {7'h00, flag_r} : 8'h00;
  assign rd_hit  = atcu_sel(araddr, `ATCU_OFF_COUNT) | atcu_sel(araddr, `ATCU_OFF_COMPARE)
                 | atcu_sel(araddr, `ATCU_OFF_CONTROL) | atcu_sel(araddr, `ATCU_OFF_STATUS)
                 | atcu_sel(araddr, `ATCU_OFF_FLAGS);

  assign awready            = awready_r;
  assign wready             = wready_r;
  assign bvalid             = bvalid_r;
  assign bresp              = bresp_r;
  assign arready            = arready_r;
  assign rvalid             = rvalid_r;
  assign rdata              = rdata_r;
  assign rresp              = rresp_r;
  assign compare_output_pin = pin_r;
  assign compare_match_flag = flag_r;
  assign wake_req           = wake_r;
  assign osc_enable         = osc_en_r;

endmodule

// file: verification/atcu_monitor.sv
// Bus handshake and power relations of the asynchronous timer
`timescale 1ns/1ps
module atcu_monitor (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Power and wake
  input wire logic        deep_sleep,
  input wire logic        sleep_active,
  input wire logic        osc_enable,
  input wire logic        wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  a_b_after: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_aw_held: assert property (awvalid && awready |=> !awready ##1 !awready)
    else $error("write address reopened early");
  a_r_next: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_ar_busy: assert property (rvalid |-> !arready)
    else $error("read address open during answer");
  a_osc_off: assert property (deep_sleep |=> !osc_enable)
    else $error("oscillator on in deep sleep");
  a_wake_cause: assert property ($rose(wake_req) |-> sleep_active)
    else $error("wake without sleep");
endmodule

// file: verification/atcu_crystal.sv
// Watch crystal model driving the timer oscillator pin
`timescale 1ns/1ps
module atcu_crystal #(
  parameter int HALF = 10
) (
  // Clock and enable
  input  wire logic aclk,
  input  wire logic osc_enable,
  // Oscillator pin
  output logic      crystal_osc_in
);
  int n = 0;
  initial crystal_osc_in = 1'b0;
  // runs only while enabled, frozen otherwise
  always @(posedge aclk) begin
    if (osc_enable) begin
      n <= (n == HALF - 1) ? 0 : n + 1;
      if (n == HALF - 1)
        crystal_osc_in <= ~crystal_osc_in;
    end
  end
endmodule

// file: verification/test_atcu_timer.sv
// Self-checking bench of the asynchronous timer
`timescale 1ns/1ps
`include "atcu_params.svh"
module test_atcu_timer;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, sleep_active = 1'b0, deep_sleep = 1'b0;
  logic        irq_ack = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d0, d1;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid, crystal_osc_in;
  wire         compare_output_pin, compare_match_flag, wake_req, osc_enable;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          error_cnt = 0, n_tests = 0, cyc = 0, t_take, t0;
  int          div [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  atcu_timer atcu_timer_inst (
    .aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .crystal_osc_in, .sleep_active, .deep_sleep, .irq_ack,
    .compare_output_pin, .compare_match_flag, .wake_req, .osc_enable
  );
  atcu_crystal #(.HALF(10)) atcu_crystal_inst (.aclk, .osc_enable, .crystal_osc_in);

  // ****
  // Bus and check tasks
  // ****
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    t_take = cyc;
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rd(`ATCU_OFF_STATUS, d0);
      k++;
    end while (d0[2:0] != 3'h0 && k < 100);
  endtask

  task automatic wait_flag();
    for (int k = 0; k < 300 && compare_match_flag !== 1'b1; k++) @(posedge aclk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), d0);
      chk("reset value", d0, 32'h0);
    end
    chk("unmapped rresp", 32'(resp), 32'(`ATCU_RESP_SLVERR));
    wr(8'h14, 32'hFF);
    chk("unmapped bresp", 32'(resp), 32'(`ATCU_RESP_SLVERR));
    $display("t_reset done");
  endtask

  // Reads exactly 8*N cycles apart see 8 ticks whatever the prescaler phase, and 0 ticks with select 0
  task automatic t_prescale();
    for (int s = 0; s < 8; s++) begin
      wr(`ATCU_OFF_CONTROL, 32'(s));
      rd(`ATCU_OFF_COUNT, d0);
      t0 = t_take;
      while (cyc != t0 + 8 * div[s] - 1) @(posedge aclk);
      rd(`ATCU_OFF_COUNT, d1);
      chk("ticks", 32'(8'(d1 - d0)), (s == 0) ? 32'h0 : 32'h8);
    end
    $display("t_prescale done");
  endtask

  task automatic t_compare();
    wr(`ATCU_OFF_CONTROL, 32'h0);
    wr(`ATCU_OFF_FLAGS, 32'h1);
    wr(`ATCU_OFF_COMPARE, 32'h20);
    wr(`ATCU_OFF_COUNT, 32'h20);
    rd(`ATCU_OFF_COUNT, d0);
    chk("count readback", d0, 32'h20);
    wr(`ATCU_OFF_CONTROL, 32'h11);
    repeat (100) @(posedge aclk);
    chk("blocked match", 32'(compare_match_flag), 32'h0);
    wait_flag();
    chk("match flag", 32'(compare_match_flag), 32'h1);
    chk("toggle pin", 32'(compare_output_pin), 32'h1);
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("ack clear", 32'(compare_match_flag), 32'h0);
    wait_flag();
    chk("second match", 32'(compare_match_flag), 32'h1);
    wr(`ATCU_OFF_FLAGS, 32'h1);
    rd(`ATCU_OFF_FLAGS, d0);
    chk("one clear", d0, 32'h0);
    $display("t_compare done");
  endtask

  task automatic t_async();
    wr(`ATCU_OFF_CONTROL, 32'h0);
    wr(`ATCU_OFF_STATUS, 32'h8);
    rd(`ATCU_OFF_STATUS, d0);
    chk("async select", d0, 32'h8);
    // Registers rewritten after the clock switch
    wr(`ATCU_OFF_COMPARE, 32'h40);
    wr(`ATCU_OFF_COUNT, 32'h30);
    rd(`ATCU_OFF_STATUS, d0);
    chk("two busy", d0, 32'hE);
    rd(`ATCU_OFF_COMPARE, d0);
    chk("compare temp", d0, 32'h40);
    wait_idle();
    chk("busy cleared", d0, 32'h8);
    wr(`ATCU_OFF_CONTROL, 32'h1);
    rd(`ATCU_OFF_STATUS, d0);
    chk("control busy", d0, 32'h9);
    wait_idle();
    rd(`ATCU_OFF_COUNT, d0);
    repeat (400) @(posedge aclk);
    rd(`ATCU_OFF_COUNT, d1);
    d1 = 32'(8'(d1 - d0));
    chk("crystal rate", 32'(d1 >= 19 && d1 <= 21), 32'h1);
    deep_sleep <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(`ATCU_OFF_COUNT, d0);
    repeat (200) @(posedge aclk);
    rd(`ATCU_OFF_COUNT, d1);
    chk("frozen count", d1, d0);
    deep_sleep <= 1'b0;
    wr(`ATCU_OFF_FLAGS, 32'h1);
    wr(`ATCU_OFF_CONTROL, 32'h1);
    wait_idle();
    sleep_active <= 1'b1;
    for (int k = 0; k < 7000 && wake_req !== 1'b1; k++) @(posedge aclk);
    chk("wake", 32'(wake_req), 32'h1);
    sleep_active <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("wake drop", 32'(wake_req), 32'h0);
    $display("t_async done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_prescale();
    t_compare();
    t_async();
    tally_and_finish();
  end

  // Whole run needs about 19000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule

bind atcu_timer atcu_monitor atcu_monitor_inst (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
  .arready, .rvalid, .rready, .rdata, .deep_sleep, .sleep_active, .osc_enable, .wake_req
);
